// [rtl/mac_frame_consts.vh]
`ifndef MAC_FRAME_CONSTS_VH
`define MAC_FRAME_CONSTS_VH

// Register offsets, byte addresses on the register port.
`define REG_COMMAND_OFFSET        8'h08
`define REG_MAX_FRAME_OFFSET      8'h14
`define REG_PAUSE_QUANTA_OFFSET   8'h18
`define REG_NEAR_FULL_OFFSET      8'h38
`define REG_STATUS_OFFSET         8'h3C

// Command register fields.
`define CMD_TX_ENABLE_BIT         0
`define CMD_RX_ENABLE_BIT         1

// Reset values.
`define COMMAND_RESET             32'h00000000
`define MAX_FRAME_RESET           16'h05EE
`define NEAR_FULL_RESET           32'h00000000

// Receive error flag positions.
`define RX_ERR_MEDIA_BIT          0
`define RX_ERR_LENGTH_BIT         1
`define RX_ERR_CRC_BIT            2

// Frame layout.
`define PREAMBLE_BYTES            16'd7
`define MIN_FRAME_NO_FCS          16'd60
`define FCS_BYTES                 16'd4
`define GAP_BYTES                 16'd12
`define PREAMBLE_BYTE             8'h55
`define SFD_BYTE                  8'hD5
`define TYPE_HI_INDEX             16'd12
`define TYPE_LO_INDEX             16'd13
`define OPCODE_HI_INDEX           16'd14
`define OPCODE_LO_INDEX           16'd15
`define QUANTA_HI_INDEX           16'd16
`define QUANTA_LO_INDEX           16'd17
`define PAUSE_TYPE                16'h8808
`define PAUSE_OPCODE              16'h0001

// CRC.
`define CRC_INIT                  32'hFFFFFFFF
`define CRC_POLY                  32'hEDB88320
`define CRC_RESIDUE               32'hDEBB20E3

// Timing.
`define CLK_PERIOD_NS             25'd5
`define PAUSE_QUANTUM_NS          25'd512

`endif

// [rtl/crc32_byte_step.v]
`timescale 1ns/100ps
`default_nettype none
`include "mac_frame_consts.vh"

module crc32_byte_step (
  input  wire [31:0] crc_in,
  input  wire [7:0]  data,
  output reg  [31:0] crc_out
);

  integer i;
  reg     feedback;

  // Reflected CRC-32, least significant bit of the byte first as on the wire.
  always @* begin
    crc_out  = crc_in;
    feedback = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      feedback = crc_out[0] ^ data[i];
      crc_out  = {1'b0, crc_out[31:1]};
      if (feedback) begin
        crc_out = crc_out ^ `CRC_POLY;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/ethernet_mac_frame_checks.v]
`timescale 1ns/100ps
`default_nettype none
`include "mac_frame_consts.vh"

module ethernet_mac_frame_checks (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_address,
  input  wire        reg_read,
  input  wire        reg_write,
  input  wire [31:0] reg_write_data,
  output reg  [31:0] reg_read_data,
  output reg         reg_waitrequest,
  input  wire [7:0]  client_transmit_data,
  input  wire        client_transmit_valid,
  input  wire        client_transmit_sop,
  input  wire        client_transmit_eop,
  output reg         client_transmit_ready,
  output reg  [7:0]  client_receive_data,
  output reg         client_receive_valid,
  output reg         client_receive_sop,
  output reg         client_receive_eop,
  output reg  [2:0]  client_receive_error,
  output reg  [7:0]  media_transmit_bytes,
  output reg         media_transmit_enable,
  input  wire [7:0]  media_receive_bytes,
  input  wire        media_receive_valid,
  input  wire        media_receive_error
);

  localparam TX_IDLE = 6'b000001;
  localparam TX_PRE  = 6'b000010;
  localparam TX_DATA = 6'b000100;
  localparam TX_PAD  = 6'b001000;
  localparam TX_FCS  = 6'b010000;
  localparam TX_GAP  = 6'b100000;
  localparam RX_IDLE = 3'b001;
  localparam RX_PRE  = 3'b010;
  localparam RX_BODY = 3'b100;

  reg  [31:0] command;
  reg  [15:0] max_frame_length_setting;
  reg  [31:0] tx_fifo_near_full_level;
  reg  [15:0] last_pause_quanta;
  reg  [24:0] pause_ns;

  reg  [5:0]  tx_state;
  reg  [15:0] tx_cnt;
  reg  [31:0] tx_crc;
  reg  [7:0]  tx_byte;
  wire [31:0] tx_crc_next;
  wire        tx_take;

  reg  [7:0]  rx_d_meta;
  reg  [7:0]  rx_d_sync;
  reg         rx_dv_meta;
  reg         rx_dv_sync;
  reg         rx_er_meta;
  reg         rx_er_sync;
  reg  [2:0]  rx_state;
  reg  [15:0] rx_cnt;
  reg  [31:0] rx_crc;
  wire [31:0] rx_crc_next;
  reg  [7:0]  rx_held;
  reg         rx_have;
  reg         rx_first;
  reg         rx_fwd;
  reg         rx_media_err;
  reg  [15:0] rx_type;
  reg  [15:0] rx_opcode;
  reg  [15:0] rx_quanta;
  wire        rx_crc_bad;
  wire        rx_too_long;
  wire        rx_is_pause;

  // Register port: waitrequest drops for exactly one cycle to complete an access.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_waitrequest          <= 1'b1;
      reg_read_data            <= 32'h00000000;
      command                  <= `COMMAND_RESET;
      max_frame_length_setting <= `MAX_FRAME_RESET;
      tx_fifo_near_full_level  <= `NEAR_FULL_RESET;
    end else begin
      reg_waitrequest <= 1'b1;
      if ((reg_read || reg_write) && reg_waitrequest) begin
        reg_waitrequest <= 1'b0;
        if (reg_write) begin
          case (reg_address)
            `REG_COMMAND_OFFSET:   command <= reg_write_data;
            `REG_MAX_FRAME_OFFSET: max_frame_length_setting <= reg_write_data[15:0];
            `REG_NEAR_FULL_OFFSET: tx_fifo_near_full_level <= reg_write_data;
            default: ;
          endcase
        end else begin
          case (reg_address)
            `REG_COMMAND_OFFSET:      reg_read_data <= command;
            `REG_MAX_FRAME_OFFSET:    reg_read_data <= {16'h0000, max_frame_length_setting};
            `REG_PAUSE_QUANTA_OFFSET: reg_read_data <= {16'h0000, last_pause_quanta};
            `REG_NEAR_FULL_OFFSET:    reg_read_data <= tx_fifo_near_full_level;
            `REG_STATUS_OFFSET:       reg_read_data <= {26'h0000000, tx_state};
            default:                  reg_read_data <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Transmit path.
  assign tx_take = client_transmit_valid && client_transmit_ready;

  always @* begin
    if (tx_state == TX_DATA && tx_take) begin
      tx_byte = client_transmit_data;
    end else begin
      tx_byte = 8'h00;
    end
  end

  crc32_byte_step tx_crc_step (
    .crc_in  (tx_crc),
    .data    (tx_byte),
    .crc_out (tx_crc_next)
  );

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state              <= TX_IDLE;
      tx_cnt                <= 16'h0000;
      tx_crc                <= `CRC_INIT;
      client_transmit_ready <= 1'b0;
      media_transmit_bytes  <= 8'h00;
      media_transmit_enable <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          media_transmit_enable <= 1'b0;
          media_transmit_bytes  <= 8'h00;
          // A pending hold-off is only looked at between frames, so a frame in flight ends.
          if (client_transmit_valid && client_transmit_sop && pause_ns == 25'd0 &&
              command[`CMD_TX_ENABLE_BIT]) begin
            tx_state <= TX_PRE;
            tx_cnt   <= 16'h0000;
            tx_crc   <= `CRC_INIT;
          end
        end
        TX_PRE: begin
          media_transmit_enable <= 1'b1;
          tx_cnt                <= tx_cnt + 16'h0001;
          if (tx_cnt == `PREAMBLE_BYTES) begin
            media_transmit_bytes  <= `SFD_BYTE;
            tx_state              <= TX_DATA;
            tx_cnt                <= 16'h0000;
            client_transmit_ready <= 1'b1;
          end else begin
            media_transmit_bytes <= `PREAMBLE_BYTE;
          end
        end
        TX_DATA: begin
          // A client gap mid-frame is sent as a zero byte; the line cannot stall.
          media_transmit_bytes <= tx_byte;
          tx_crc               <= tx_crc_next;
          tx_cnt               <= tx_cnt + 16'h0001;
          if (tx_take && client_transmit_eop) begin
            client_transmit_ready <= 1'b0;
            if (tx_cnt + 16'h0001 < `MIN_FRAME_NO_FCS) begin
              tx_state <= TX_PAD;
            end else begin
              tx_state <= TX_FCS;
              tx_cnt   <= 16'h0000;
            end
          end
        end
        TX_PAD: begin
          media_transmit_bytes <= 8'h00;
          tx_crc               <= tx_crc_next;
          tx_cnt               <= tx_cnt + 16'h0001;
          if (tx_cnt + 16'h0001 == `MIN_FRAME_NO_FCS) begin
            tx_state <= TX_FCS;
            tx_cnt   <= 16'h0000;
          end
        end
        TX_FCS: begin
          media_transmit_bytes <= ~tx_crc[8 * tx_cnt[1:0] +: 8];
          tx_cnt               <= tx_cnt + 16'h0001;
          if (tx_cnt + 16'h0001 == `FCS_BYTES) begin
            tx_state <= TX_GAP;
            tx_cnt   <= 16'h0000;
          end
        end
        TX_GAP: begin
          media_transmit_enable <= 1'b0;
          media_transmit_bytes  <= 8'h00;
          tx_cnt                <= tx_cnt + 16'h0001;
          if (tx_cnt + 16'h0001 == `GAP_BYTES) begin
            tx_state <= TX_IDLE;
          end
        end
        default: begin
          tx_state              <= TX_IDLE;
          client_transmit_ready <= 1'b0;
          media_transmit_enable <= 1'b0;
        end
      endcase
    end
  end

  // Media inputs come from the pins and are synchronised before use.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_d_meta  <= 8'h00;
      rx_d_sync  <= 8'h00;
      rx_dv_meta <= 1'b0;
      rx_dv_sync <= 1'b0;
      rx_er_meta <= 1'b0;
      rx_er_sync <= 1'b0;
    end else begin
      rx_d_meta  <= media_receive_bytes;
      rx_d_sync  <= rx_d_meta;
      rx_dv_meta <= media_receive_valid;
      rx_dv_sync <= rx_dv_meta;
      rx_er_meta <= media_receive_error;
      rx_er_sync <= rx_er_meta;
    end
  end

  crc32_byte_step rx_crc_step (
    .crc_in  (rx_crc),
    .data    (rx_d_sync),
    .crc_out (rx_crc_next)
  );

  assign rx_crc_bad  = (rx_crc != `CRC_RESIDUE);
  assign rx_too_long = (rx_cnt > max_frame_length_setting);
  assign rx_is_pause = (rx_type == `PAUSE_TYPE) && (rx_opcode == `PAUSE_OPCODE);

  // Receive path holds one byte back so the last byte can carry the end mark and flags.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state             <= RX_IDLE;
      rx_cnt               <= 16'h0000;
      rx_crc               <= `CRC_INIT;
      rx_held              <= 8'h00;
      rx_have              <= 1'b0;
      rx_first             <= 1'b0;
      rx_fwd               <= 1'b0;
      rx_media_err         <= 1'b0;
      rx_type              <= 16'h0000;
      rx_opcode            <= 16'h0000;
      rx_quanta            <= 16'h0000;
      last_pause_quanta    <= 16'h0000;
      pause_ns             <= 25'd0;
      client_receive_data  <= 8'h00;
      client_receive_valid <= 1'b0;
      client_receive_sop   <= 1'b0;
      client_receive_eop   <= 1'b0;
      client_receive_error <= 3'b000;
    end else begin
      client_receive_valid <= 1'b0;
      client_receive_sop   <= 1'b0;
      client_receive_eop   <= 1'b0;
      client_receive_error <= 3'b000;
      if (pause_ns > `CLK_PERIOD_NS) begin
        pause_ns <= pause_ns - `CLK_PERIOD_NS;
      end else begin
        pause_ns <= 25'd0;
      end
      case (rx_state)
        RX_IDLE: begin
          if (rx_dv_sync) begin
            rx_state <= RX_PRE;
          end
        end
        RX_PRE: begin
          if (!rx_dv_sync) begin
            rx_state <= RX_IDLE;
          end else if (rx_d_sync == `SFD_BYTE) begin
            rx_state     <= RX_BODY;
            rx_cnt       <= 16'h0000;
            rx_crc       <= `CRC_INIT;
            rx_have      <= 1'b0;
            rx_first     <= 1'b1;
            rx_media_err <= 1'b0;
            rx_fwd       <= command[`CMD_RX_ENABLE_BIT];
          end
        end
        RX_BODY: begin
          if (rx_dv_sync) begin
            rx_crc       <= rx_crc_next;
            rx_held      <= rx_d_sync;
            rx_have      <= 1'b1;
            rx_cnt       <= rx_cnt + 16'h0001;
            rx_media_err <= rx_media_err | rx_er_sync;
            case (rx_cnt)
              `TYPE_HI_INDEX:   rx_type[15:8]   <= rx_d_sync;
              `TYPE_LO_INDEX:   rx_type[7:0]    <= rx_d_sync;
              `OPCODE_HI_INDEX: rx_opcode[15:8] <= rx_d_sync;
              `OPCODE_LO_INDEX: rx_opcode[7:0]  <= rx_d_sync;
              `QUANTA_HI_INDEX: rx_quanta[15:8] <= rx_d_sync;
              `QUANTA_LO_INDEX: rx_quanta[7:0]  <= rx_d_sync;
              default: ;
            endcase
            if (rx_have && rx_fwd) begin
              client_receive_data  <= rx_held;
              client_receive_valid <= 1'b1;
              client_receive_sop   <= rx_first;
              rx_first             <= 1'b0;
            end
          end else begin
            rx_state <= RX_IDLE;
            rx_type  <= 16'h0000;
            // Short frames are not dropped and carry no length flag; an empty frame gives no output.
            if (rx_have && rx_fwd) begin
              client_receive_data  <= rx_held;
              client_receive_valid <= 1'b1;
              client_receive_sop   <= rx_first;
              client_receive_eop   <= 1'b1;
              client_receive_error[`RX_ERR_CRC_BIT]    <= rx_crc_bad;
              client_receive_error[`RX_ERR_LENGTH_BIT] <= rx_too_long;
              client_receive_error[`RX_ERR_MEDIA_BIT]  <= rx_media_err;
            end
            // Pause frames act whatever the receive enable, but only when intact.
            if (rx_is_pause && !rx_crc_bad && !rx_media_err) begin
              last_pause_quanta <= rx_quanta;
              pause_ns          <= rx_quanta * `PAUSE_QUANTUM_NS;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// [bench/mac_frame_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module mac_frame_chk (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_address,
  input wire logic        reg_read,
  input wire logic        reg_write,
  input wire logic [31:0] reg_write_data,
  input wire logic        reg_waitrequest,
  input wire logic        client_transmit_ready,
  input wire logic        client_receive_valid,
  input wire logic        client_receive_sop,
  input wire logic        client_receive_eop,
  input wire logic [7:0]  media_transmit_bytes,
  input wire logic        media_transmit_enable
);
  logic [7:0] en_len;
  logic       rx_on;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_len <= 8'h00;
      rx_on  <= 1'b0;
    end else begin
      en_len <= media_transmit_enable ? en_len + 8'h01 : 8'h00;
      if (reg_write && reg_waitrequest && reg_address == 8'h08)
        rx_on <= reg_write_data[1];
    end
  end
  sequence s_preamble;
    (media_transmit_bytes == 8'h55) [*7] ##1 (media_transmit_bytes == 8'hD5);
  endsequence
  sequence s_gap;
    (!media_transmit_enable) [*8] ##1 (!media_transmit_enable) [*4];
  endsequence
  a_wait_one: assert property (
    (reg_read || reg_write) && reg_waitrequest |=> !reg_waitrequest
  ) else $error("access not answered");
  a_wait_pulse: assert property (
    !reg_waitrequest |=> reg_waitrequest
  ) else $error("wait low too long");
  a_tx_preamble: assert property (
    $rose(media_transmit_enable) |-> s_preamble
  ) else $error("bad preamble");
  a_tx_gap: assert property (
    $fell(media_transmit_enable) |-> s_gap
  ) else $error("gap too short");
  a_tx_min_len: assert property (
    $fell(media_transmit_enable) |-> en_len >= 8'd72
  ) else $error("frame below minimum");
  a_ready_in_frame: assert property (
    client_transmit_ready |-> media_transmit_enable
  ) else $error("ready outside frame");
  a_rx_gated: assert property (
    client_receive_sop |-> rx_on
  ) else $error("frame passed while disabled");
  a_rx_sop_valid: assert property (
    client_receive_sop |-> client_receive_valid
  ) else $error("sop without valid");
  a_rx_eop_valid: assert property (
    client_receive_eop |-> client_receive_valid && !client_receive_sop
  ) else $error("eop without valid");
endmodule
bind ethernet_mac_frame_checks mac_frame_chk u_chk (.*);
`default_nettype wire

// [bench/mac_phy_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mac_phy_model (
  input wire logic       core_clk,
  input wire logic [7:0] media_transmit_bytes,
  input wire logic       media_transmit_enable,
  input wire logic       loop_on,
  output logic [7:0]     media_receive_bytes,
  output logic           media_receive_valid,
  output logic           media_receive_error
);
  logic [7:0] tx_log[$];
  logic       busy;
  initial begin
    media_receive_bytes = 8'h00;
    media_receive_valid = 1'b0;
    media_receive_error = 1'b0;
    busy = 1'b0;
  end
  // Idle data toggles so a design that samples outside valid cannot pass by luck.
  always @(posedge core_clk) begin
    if (media_transmit_enable === 1'b1) tx_log.push_back(media_transmit_bytes);
    if (!busy) begin
      media_receive_valid <= loop_on && media_transmit_enable;
      media_receive_bytes <= media_transmit_enable ? media_transmit_bytes : ~media_receive_bytes;
    end
  end
  task automatic send(input logic [7:0] f[$]);
    busy = 1'b1;
    for (int i = 0; i < f.size() + 8; i++) begin
      @(posedge core_clk);
      media_receive_valid <= 1'b1;
      media_receive_bytes <= (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : f[i - 8];
    end
    // The idle process takes the lines back at the next edge, so one driver per edge.
    #1;
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/tb_ethernet_mac_frame_checks.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_ethernet_mac_frame_checks;
  logic        core_clk, rst_n, reg_read, reg_write, reg_waitrequest, loop_on;
  logic        client_transmit_valid, client_transmit_sop, client_transmit_eop;
  logic        client_transmit_ready, client_receive_valid, client_receive_sop;
  logic        client_receive_eop, media_transmit_enable, media_receive_valid;
  logic        media_receive_error;
  logic [2:0]  client_receive_error;
  logic [7:0]  reg_address, client_transmit_data, client_receive_data;
  logic [7:0]  media_transmit_bytes, media_receive_bytes;
  logic [31:0] reg_write_data, reg_read_data, rd;
  logic [7:0]  fr[$], exp_q[$], rx_got[$];
  logic [2:0]  err_got[$];
  int          fail_count, n_compared, cyc, t_rise, e, d;
  ethernet_mac_frame_checks uut (.*);
  mac_phy_model phy (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (client_receive_valid === 1'b1) rx_got.push_back(client_receive_data);
    if (client_receive_eop === 1'b1) err_got.push_back(client_receive_error);
  end
  always @(posedge media_transmit_enable) t_rise = cyc;
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic chk_q(input string what, input logic [7:0] ex[$], input logic [7:0] got[$]);
    chk({what, " length"}, ex.size(), got.size());
    foreach (ex[i]) if (i < got.size()) chk(what, ex[i], got[i]);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic reg_acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    reg_write = w;
    reg_read = !w;
    reg_address = a;
    reg_write_data = v;
    do step(1); while (reg_waitrequest !== 1'b0);
    rd = reg_read_data;
    step(1);
    reg_write = 1'b0;
    reg_read = 1'b0;
  endtask
  task automatic tx_frame(input logic [7:0] q[$]);
    int   i;
    logic tk;
    i = 0;
    while (i < q.size()) begin
      client_transmit_valid = 1'b1;
      client_transmit_sop = (i == 0);
      client_transmit_eop = (i == q.size() - 1);
      client_transmit_data = q[i];
      tk = (client_transmit_ready === 1'b1);
      step(1);
      if (tk) i++;
    end
    client_transmit_valid = 1'b0;
  endtask
  function automatic void build(input int pay);
    fr = {};
    repeat (12) fr.push_back(8'($urandom));
    fr.push_back(8'(pay >> 8));
    fr.push_back(8'(pay));
    repeat (pay) fr.push_back(8'($urandom));
  endfunction
  function automatic void add_fcs(input logic pad, input logic bad);
    logic [31:0] c;
    exp_q = fr;
    while (pad && exp_q.size() < 60) exp_q.push_back(8'h00);
    c = 32'hFFFFFFFF;
    foreach (exp_q[i]) begin
      c = c ^ {24'h0, exp_q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) exp_q.push_back(c[8*i +: 8]);
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, reg_read, reg_write, loop_on, client_transmit_valid} = '0;
    {client_transmit_sop, client_transmit_eop, client_transmit_data} = '0;
    reg_address = 8'h00;
    reg_write_data = 32'h0;
    void'($urandom(33));
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    reg_acc(1'b0, 8'h08, 32'h0);
    chk("command", 32'h0, rd);
    reg_acc(1'b0, 8'h14, 32'h0);
    chk("max frame", 32'h000005EE, rd);
    reg_acc(1'b0, 8'h38, 32'h0);
    chk("near full reset", 32'h0, rd);
    e = $urandom;
    reg_acc(1'b1, 8'h38, e);
    reg_acc(1'b0, 8'h38, 32'h0);
    chk("near full", e, rd);
    reg_acc(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("registers done");
    loop_on = 1'b1;
    reg_acc(1'b1, 8'h08, 32'h1);
    build(0);
    add_fcs(1'b1, 1'b0);
    for (int p = 0; p < 2; p++) begin
      rx_got = {};
      phy.tx_log = {};
      tx_frame(fr);
      step(100);
      chk_q("wire frame", {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5, exp_q},
            phy.tx_log);
      if (p == 0) chk("bytes while disabled", 32'h0, rx_got.size());
      else chk_q("loop receive", exp_q, rx_got);
      reg_acc(1'b1, 8'h08, 32'h3);
    end
    $display("transmit done");
    loop_on = 1'b0;
    reg_acc(1'b1, 8'h14, 32'h40);
    for (int c = 0; c < 3; c++) begin
      build((c == 0) ? 0 : 45 + c);
      add_fcs(1'b0, c == 0);
      rx_got = {};
      err_got = {};
      phy.send(exp_q);
      step(10);
      chk_q("rx frame", exp_q, rx_got);
      chk("rx error", {c == 0, exp_q.size() > 64, 1'b0}, err_got[0]);
    end
    $display("receive done");
    e = $urandom_range(3, 1);
    build(0);
    fr[12] = 8'h88;
    fr[13] = 8'h08;
    fr = {fr, 8'h00, 8'h01, 8'(e >> 8), 8'(e)};
    add_fcs(1'b1, 1'b0);
    err_got = {};
    phy.send(exp_q);
    while (err_got.size() == 0) step(1);
    d = cyc;
    build(0);
    tx_frame(fr);
    step(100);
    reg_acc(1'b0, 8'h18, 32'h0);
    chk("pause quanta", e, rd);
    e = (e * 512 + 4) / 5;
    d = t_rise - d;
    chk("pause cycles", e, (d >= e - 3 && d <= e + 6) ? e : d);
    $display("pause done");
    rst_n = 1'b0;
    step(2);
    chk("wait in reset", 32'h1, reg_waitrequest);
    rst_n = 1'b1;
    reg_acc(1'b0, 8'h38, 32'h0);
    chk("near full after reset", 32'h0, rd);
    reg_acc(1'b0, 8'h08, 32'h0);
    chk("command after reset", 32'h0, rd);
    $display("reset done");
    tally_and_finish();
  end
  // The tests need about 1,000 cycles; this allows roughly twenty times that.
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
